//--- src/floppy_command_phase_engine.sv
`timescale 1ns/1ps
// Overview of operation
// - two 8-bit ports: status, then data
// - status port readable in every phase
// - data port walks an internal byte stack
// - fifteen commands are recognised, fourteen of them multi-byte
// - command, execution, result phases in order
// - last parameter starts execution automatically
// - last result read ends the command
// - new command refused until results drained
// - result status bytes only in result phase
// - main status bit layout, drives busy low
// - status zero bit layout
// - status one layout, bits 6 and 3 zero
// - status two layout, bit 7 zero
// - status three layout
// - opcode bits 7, 6 are track and density
// - bit 5 skips deleted marks on reads
// - unit byte gives head and drive select
// - nine-byte parameter order fixed
// - data commands return seven result bytes
// - read track forbids multi-track, reads whole track
// - read identifier returns captured sector id
// - low five opcode bits select the command
// - invalid opcode answers status zero, msb set
module floppy_command_phase_engine (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [9:0] io_addr,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic exec_start,
  output cmd_engine_pkg::exec_request_t exec_req,
  input wire logic exec_done,
  input wire cmd_engine_pkg::exec_result_t exec_res,
  input wire logic [3:0] drive_seeking,
  output cmd_engine_pkg::status_zero_t result_status_zero,
  output cmd_engine_pkg::status_one_t result_status_one,
  output cmd_engine_pkg::status_two_t result_status_two,
  output cmd_engine_pkg::status_three_t result_status_three
);

  // ************************************************************
  // phase machine and state record
  // ************************************************************
  typedef enum logic [3:0] {
    PH_IDLE = 4'b0001,
    PH_PARAM = 4'b0010,
    PH_EXEC = 4'b0100,
    PH_RESULT = 4'b1000
  } phase_t;

  typedef struct packed {
    phase_t phase;
    logic [3:0] count;
    cmd_engine_pkg::cmd_info_t info;
    logic [8:0][7:0] bytes;
    logic [7:0] rdata;
    logic start;
    cmd_engine_pkg::exec_request_t req;
    cmd_engine_pkg::main_status_t msr;
    cmd_engine_pkg::status_zero_t st0;
    cmd_engine_pkg::status_one_t st1;
    cmd_engine_pkg::status_two_t st2;
    cmd_engine_pkg::status_three_t st3;
  } engine_state_t;

  engine_state_t state_reg;
  engine_state_t state_next;

  // ************************************************************
  // helpers
  // ************************************************************
  cmd_engine_pkg::cmd_info_t op_info;
  logic [7:0] stack_head;
  logic stack_last;
  logic stack_load;
  logic [6:0][7:0] stack_bytes;
  logic [2:0] stack_count;
  logic stack_pop;
  logic status_sel;
  logic data_sel;

  assign status_sel = io_addr == cmd_engine_pkg::MAIN_STATUS_ADDR;
  assign data_sel = io_addr == cmd_engine_pkg::DATA_PORT_ADDR;

  opcode_decoder u_decoder (
    .opcode(io_wdata),
    .info(op_info)
  );

  result_stack u_stack (
    .core_clk(core_clk),
    .nrst(nrst),
    .load(stack_load),
    .load_bytes(stack_bytes),
    .load_count(stack_count),
    .pop(stack_pop),
    .head_byte(stack_head),
    .last_byte(stack_last)
  );

  // builds the execution request from the collected command bytes
  function automatic cmd_engine_pkg::exec_request_t
      make_request(input logic [8:0][7:0] b);
    cmd_engine_pkg::exec_request_t r;
    r = '0;
    r.raw_bytes = b;
    r.cmd_code = b[0][4:0];
    r.multi_track = b[0][cmd_engine_pkg::OPT_MT_BIT];
    r.double_density_sel = b[0][cmd_engine_pkg::OPT_DENSITY_BIT];
    r.bypass_deleted = b[0][cmd_engine_pkg::OPT_SKIP_BIT];
    // bits 7..3 of the unit byte are ignored
    r.head_index = b[1][2];
    r.drive_sel_hi = b[1][1];
    r.drive_sel_lo = b[1][0];
    r.cylinder = b[2];
    r.head_no = b[3];
    r.sector = b[4];
    r.size_code = b[5];
    r.last_sector = b[6];
    r.gap_three_len = b[7];
    r.transfer_length = b[8];
    return r;
  endfunction

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    state_next = state_reg;
    state_next.start = 1'b0;
    stack_load = 1'b0;
    stack_bytes = '0;
    stack_count = 3'h0;
    stack_pop = 1'b0;

    // status port answers in any phase
    if (io_rd && status_sel) begin
      state_next.rdata = state_reg.msr;
    end else if (io_rd && data_sel) begin
      // outside the result phase there is nothing to hand out
      state_next.rdata = 8'h00;
    end

    case (state_reg.phase)
      PH_IDLE: begin
        state_next.count = 4'h0;
        if (io_wr && data_sel) begin
          state_next.bytes = '0;
          state_next.bytes[0] = io_wdata;
          state_next.info = op_info;
          state_next.count = 4'h1;
          if (!op_info.valid) begin
            // no execution: answer a single status zero byte
            stack_load = 1'b1;
            stack_bytes[0] = cmd_engine_pkg::INVALID_ST0;
            stack_count = 3'h1;
            state_next.st0 = cmd_engine_pkg::INVALID_ST0;
            state_next.phase = PH_RESULT;
          end else if (op_info.cmd_bytes == 4'h1) begin
            state_next.req = make_request(state_next.bytes);
            state_next.start = 1'b1;
            state_next.phase = PH_EXEC;
          end else begin
            state_next.phase = PH_PARAM;
          end
        end
      end
      PH_PARAM: begin
        if (io_wr && data_sel) begin
          state_next.bytes[state_reg.count] = io_wdata;
          state_next.count = state_reg.count + 4'h1;
          if (state_next.count == state_reg.info.cmd_bytes) begin
            state_next.req = make_request(state_next.bytes);
            state_next.start = 1'b1;
            state_next.phase = PH_EXEC;
          end
        end
      end
      PH_EXEC: begin
        // host writes here are not taken: transfer-ready is low
        if (exec_done) begin
          state_next.st0 = exec_res.st0;
          state_next.st1 = exec_res.st1 & cmd_engine_pkg::ST1_ZERO_MASK;
          state_next.st2 = exec_res.st2 & cmd_engine_pkg::ST2_ZERO_MASK;
          state_next.st3 = exec_res.st3;
          stack_count = state_reg.info.result_bytes;
          case (state_reg.info.result_bytes)
            cmd_engine_pkg::MAX_RESULT_BYTES: begin
              stack_bytes[0] = exec_res.st0;
              stack_bytes[1] = state_next.st1;
              stack_bytes[2] = state_next.st2;
              stack_bytes[3] = exec_res.cylinder;
              stack_bytes[4] = exec_res.head_no;
              stack_bytes[5] = exec_res.sector;
              stack_bytes[6] = exec_res.size_code;
            end
            3'h2: begin
              // interrupt sense: status zero then present cylinder
              stack_bytes[0] = exec_res.st0;
              stack_bytes[1] = exec_res.cylinder;
            end
            3'h1: begin
              stack_bytes[0] = exec_res.st3;
            end
            default: begin
              stack_bytes = '0;
            end
          endcase
          if (state_reg.info.result_bytes == 3'h0) begin
            state_next.phase = PH_IDLE;
          end else begin
            stack_load = 1'b1;
            state_next.phase = PH_RESULT;
          end
        end
      end
      PH_RESULT: begin
        // writes here are dropped until the stack is drained
        if (io_rd && data_sel) begin
          state_next.rdata = stack_head;
          stack_pop = 1'b1;
          if (stack_last) begin
            state_next.phase = PH_IDLE;
          end
        end
      end
      default: begin
        state_next.phase = PH_IDLE;
      end
    endcase

    // status byte follows the phase the next cycle will be in
    state_next.msr.host_transfer_ok =
      state_next.phase != PH_EXEC;
    state_next.msr.transfer_direction =
      state_next.phase == PH_RESULT;
    state_next.msr.executing_flag = state_next.phase == PH_EXEC;
    state_next.msr.controller_busy = state_next.phase != PH_IDLE;
    state_next.msr.drive3_seeking = drive_seeking[3];
    state_next.msr.drive2_seeking = drive_seeking[2];
    state_next.msr.drive1_seeking = drive_seeking[1];
    state_next.msr.drive0_seeking = drive_seeking[0];
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state_reg <= '0;
      state_reg.phase <= PH_IDLE;
      state_reg.msr.host_transfer_ok <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign io_rdata = state_reg.rdata;
  assign exec_start = state_reg.start;
  assign exec_req = state_reg.req;
  assign result_status_zero = state_reg.st0;
  assign result_status_one = state_reg.st1;
  assign result_status_two = state_reg.st2;
  assign result_status_three = state_reg.st3;

endmodule // floppy_command_phase_engine

//--- inc/cmd_engine_pkg.sv
package cmd_engine_pkg;

  // ************************************************************
  // host port map
  // ************************************************************
  localparam logic [9:0] MAIN_STATUS_ADDR = 10'h3f4;
  localparam logic [9:0] DATA_PORT_ADDR = 10'h3f5;

  // ************************************************************
  // opcode layout and codes
  // ************************************************************
  localparam int OPT_MT_BIT = 7;
  localparam int OPT_DENSITY_BIT = 6;
  localparam int OPT_SKIP_BIT = 5;
  localparam logic [4:0] OP_READ_DATA = 5'h06;
  localparam logic [4:0] OP_READ_TRACK = 5'h02;
  localparam logic [4:0] OP_READ_DELETED = 5'h0c;
  localparam logic [4:0] OP_READ_ID = 5'h0a;
  localparam logic [4:0] OP_WRITE_DATA = 5'h05;
  localparam logic [4:0] OP_WRITE_DELETED = 5'h09;
  localparam logic [4:0] OP_FORMAT = 5'h0d;
  localparam logic [4:0] OP_SCAN_EQ = 5'h11;
  localparam logic [4:0] OP_SCAN_LE = 5'h19;
  localparam logic [4:0] OP_SCAN_HE = 5'h1d;
  localparam logic [4:0] OP_RECAL = 5'h07;
  localparam logic [4:0] OP_SENSE_INT = 5'h08;
  localparam logic [4:0] OP_SPECIFY = 5'h03;
  localparam logic [4:0] OP_SEEK = 5'h0f;
  localparam logic [4:0] OP_SENSE_DRIVE = 5'h04;
  localparam logic [7:0] INVALID_ST0 = 8'h80;
  localparam logic [7:0] ST1_ZERO_MASK = 8'hb7;
  localparam logic [7:0] ST2_ZERO_MASK = 8'h7f;
  localparam logic [3:0] MAX_CMD_BYTES = 4'h9;
  localparam logic [2:0] MAX_RESULT_BYTES = 3'h7;

  // ************************************************************
  // status byte layouts
  // ************************************************************
  typedef struct packed {
    logic host_transfer_ok;
    logic transfer_direction;
    logic executing_flag;
    logic controller_busy;
    logic drive3_seeking;
    logic drive2_seeking;
    logic drive1_seeking;
    logic drive0_seeking;
  } main_status_t;

  typedef struct packed {
    logic irq_cause_a;
    logic irq_cause_b;
    logic positioning_done;
    logic unit_trouble;
    logic drive_absent;
    logic head_index;
    logic drive_sel_hi;
    logic drive_sel_lo_alt;
  } status_zero_t;

  typedef struct packed {
    logic cylinder_end;
    logic zero6;
    logic crc_fault_id;
    logic data_overrun;
    logic zero3;
    logic sector_missing;
    logic write_refused;
    logic id_sync_absent;
  } status_one_t;

  typedef struct packed {
    logic zero7;
    logic deleted_seen;
    logic crc_fault_field;
    logic track_mismatch;
    logic compare_hit;
    logic compare_unmet;
    logic bad_track;
    logic field_sync_absent;
  } status_two_t;

  typedef struct packed {
    logic drive_fault;
    logic write_protected;
    logic drive_ready;
    logic at_outer_track;
    logic double_sided;
    logic head_index;
    logic drive_sel_hi;
    logic drive_sel_lo;
  } status_three_t;

  // ************************************************************
  // decoder and execution carriers
  // ************************************************************
  typedef struct packed {
    logic valid;
    logic [3:0] cmd_bytes;
    logic [2:0] result_bytes;
  } cmd_info_t;

  typedef struct packed {
    logic [4:0] cmd_code;
    logic multi_track;
    logic double_density_sel;
    logic bypass_deleted;
    logic head_index;
    logic drive_sel_hi;
    logic drive_sel_lo;
    logic [7:0] cylinder;
    logic [7:0] head_no;
    logic [7:0] sector;
    logic [7:0] size_code;
    logic [7:0] last_sector;
    logic [7:0] gap_three_len;
    logic [7:0] transfer_length;
    logic [8:0][7:0] raw_bytes;
  } exec_request_t;

  typedef struct packed {
    status_zero_t st0;
    status_one_t st1;
    status_two_t st2;
    status_three_t st3;
    logic [7:0] cylinder;
    logic [7:0] head_no;
    logic [7:0] sector;
    logic [7:0] size_code;
  } exec_result_t;

endpackage

//--- src/opcode_decoder.sv
`timescale 1ns/1ps
module opcode_decoder (
  input wire logic [7:0] opcode,
  output cmd_engine_pkg::cmd_info_t info
);

  // ************************************************************
  // per-command byte counts and permitted option bits
  // ************************************************************
  logic [2:0] allowed;
  logic known;

  always_comb begin
    known = 1'b1;
    allowed = 3'b000;
    info = '0;
    case (opcode[4:0])
      cmd_engine_pkg::OP_READ_DATA: begin
        allowed = 3'b111;
        info.cmd_bytes = 4'h9;
        info.result_bytes = 3'h7;
      end
      cmd_engine_pkg::OP_READ_TRACK: begin
        allowed = 3'b011;
        info.cmd_bytes = 4'h9;
        info.result_bytes = 3'h7;
      end
      cmd_engine_pkg::OP_READ_DELETED: begin
        allowed = 3'b111;
        info.cmd_bytes = 4'h9;
        info.result_bytes = 3'h7;
      end
      cmd_engine_pkg::OP_READ_ID: begin
        allowed = 3'b010;
        info.cmd_bytes = 4'h2;
        info.result_bytes = 3'h7;
      end
      cmd_engine_pkg::OP_WRITE_DATA, cmd_engine_pkg::OP_WRITE_DELETED: begin
        allowed = 3'b110;
        info.cmd_bytes = 4'h9;
        info.result_bytes = 3'h7;
      end
      cmd_engine_pkg::OP_FORMAT: begin
        allowed = 3'b010;
        info.cmd_bytes = 4'h6;
        info.result_bytes = 3'h7;
      end
      cmd_engine_pkg::OP_SCAN_EQ, cmd_engine_pkg::OP_SCAN_LE,
      cmd_engine_pkg::OP_SCAN_HE: begin
        allowed = 3'b111;
        info.cmd_bytes = 4'h9;
        info.result_bytes = 3'h7;
      end
      cmd_engine_pkg::OP_RECAL: begin
        info.cmd_bytes = 4'h2;
        info.result_bytes = 3'h0;
      end
      cmd_engine_pkg::OP_SENSE_INT: begin
        info.cmd_bytes = 4'h1;
        info.result_bytes = 3'h2;
      end
      cmd_engine_pkg::OP_SPECIFY, cmd_engine_pkg::OP_SEEK: begin
        info.cmd_bytes = 4'h3;
        info.result_bytes = 3'h0;
      end
      cmd_engine_pkg::OP_SENSE_DRIVE: begin
        info.cmd_bytes = 4'h2;
        info.result_bytes = 3'h1;
      end
      default: begin
        known = 1'b0;
      end
    endcase
    // forbidden option bits make the opcode invalid
    info.valid = known && ((opcode[7:5] & ~allowed) == 3'b000);
  end

endmodule // opcode_decoder

//--- src/result_stack.sv
`timescale 1ns/1ps
module result_stack (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic load,
  input wire logic [6:0][7:0] load_bytes,
  input wire logic [2:0] load_count,
  input wire logic pop,
  output logic [7:0] head_byte,
  output logic last_byte
);

  // ************************************************************
  // stack of result bytes, slot 0 leaves first
  // ************************************************************
  typedef struct packed {
    logic [6:0][7:0] mem;
    logic [2:0] idx;
    logic [2:0] count;
  } stack_state_t;

  stack_state_t state_reg;
  stack_state_t state_next;

  always_comb begin
    state_next = state_reg;
    if (load) begin
      state_next.mem = load_bytes;
      state_next.idx = 3'h0;
      state_next.count = load_count;
    end else if (pop && state_reg.idx != state_reg.count) begin
      state_next.idx = state_reg.idx + 3'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign head_byte = state_reg.mem[state_reg.idx];
  assign last_byte = (state_reg.idx + 3'h1) == state_reg.count;

endmodule // result_stack

//--- test/floppy_engine_properties.sv
`timescale 1ns/1ps
// ************************************************************
// port checks of the command engine
// ************************************************************
module floppy_engine_props (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [9:0] io_addr,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [7:0] io_rdata,
  input wire logic exec_start,
  input wire cmd_engine_pkg::exec_request_t exec_req,
  input wire logic [3:0] drive_seeking,
  input wire cmd_engine_pkg::status_one_t result_status_one,
  input wire cmd_engine_pkg::status_two_t result_status_two
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_start;
    exec_start;
  endsequence
  // the drive bits need one clean edge after reset to be copied in
  sequence s_status_read;
    $past(nrst) && io_rd &&
    io_addr == cmd_engine_pkg::MAIN_STATUS_ADDR ##1 !io_rd;
  endsequence
  AST_EXEC_PULSE: assert property (s_start |=> !exec_start [*2])
    else $error("execution start is not a single pulse");
  AST_START_FROM_WR: assert property (s_start |->
    $past(io_wr) && $past(io_addr) == cmd_engine_pkg::DATA_PORT_ADDR)
    else $error("execution started without a data write");
  AST_REQ_STABLE: assert property (s_start |=> $stable(exec_req))
    else $error("request fields moved after start");
  AST_ST1_ZEROS: assert property (!result_status_one.zero6 &&
    !result_status_one.zero3)
    else $error("status one fixed bits not zero");
  AST_ST2_ZERO: assert property (!result_status_two.zero7)
    else $error("status two top bit not zero");
  AST_MSR_DRIVES: assert property (s_status_read |=>
    io_rdata[3:0] == $past(drive_seeking, 3))
    else $error("main status drive bits wrong");
  AST_RESET_IDLE: assert property ($rose(nrst) |->
    io_rdata == 8'h00 && !exec_start)
    else $error("outputs not idle after reset");
  AST_RDATA_HOLD: assert property ($past(nrst) && !$past(io_rd) &&
    !$past(io_rd, 2) |-> $stable(io_rdata))
    else $error("read data moved without a read");
endmodule // floppy_engine_props

bind floppy_command_phase_engine floppy_engine_props u_props (
  .core_clk(core_clk),
  .nrst(nrst),
  .io_addr(io_addr),
  .io_rd(io_rd),
  .io_wr(io_wr),
  .io_rdata(io_rdata),
  .exec_start(exec_start),
  .exec_req(exec_req),
  .drive_seeking(drive_seeking),
  .result_status_one(result_status_one),
  .result_status_two(result_status_two)
);

//--- test/exec_engine_model.sv
`timescale 1ns/1ps
// ************************************************************
// execution engine stand-in
// ************************************************************
module exec_engine_model (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic exec_start,
  input wire logic [4:0] delay,
  input wire cmd_engine_pkg::exec_result_t res_in,
  output logic exec_done,
  output cmd_engine_pkg::exec_result_t exec_res
);
  logic busy = 1'b0;
  logic [4:0] cnt = 5'h00;
  initial exec_done = 1'b0;
  always @(posedge core_clk) begin
    exec_done <= 1'b0;
    if (!nrst) begin
      busy <= 1'b0;
    end else if (exec_start) begin
      busy <= 1'b1;
      cnt <= delay;
    end else if (busy && cnt == 5'h00) begin
      busy <= 1'b0;
      exec_done <= 1'b1;
    end else if (busy) begin
      cnt <= cnt - 5'h01;
    end
  end
  // inverse outside the pulse so a capture at the wrong cycle shows
  assign exec_res = exec_done ? res_in : ~res_in;
endmodule // exec_engine_model

//--- test/floppy_command_phase_engine_tb.sv
`timescale 1ns/1ps
module floppy_command_phase_engine_tb;
  typedef logic [7:0] bq_t[$];
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [9:0] io_addr = 10'h000;
  logic io_rd = 1'b0;
  logic io_wr = 1'b0;
  logic [7:0] io_wdata = 8'h00;
  logic [3:0] drive_seeking = 4'h0;
  logic [4:0] delay = 5'h00;
  logic [7:0] io_rdata;
  logic exec_start;
  logic exec_done;
  cmd_engine_pkg::exec_request_t exec_req;
  cmd_engine_pkg::exec_result_t exec_res;
  cmd_engine_pkg::exec_result_t res = '0;
  cmd_engine_pkg::status_zero_t st0_o;
  cmd_engine_pkg::status_one_t st1_o;
  cmd_engine_pkg::status_two_t st2_o;
  cmd_engine_pkg::status_three_t st3_o;
  logic [8:0] exp_q[$];
  logic [8:0] e;
  logic rd_d = 1'b0;
  logic rd_d2 = 1'b0;
  bq_t none;
  int bad_count = 0;
  int n_tests = 0;
  int n_start = 0;

  always #5 core_clk = ~core_clk;

  floppy_command_phase_engine DUT (
    .core_clk(core_clk), .nrst(nrst), .io_addr(io_addr), .io_rd(io_rd),
    .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .exec_start(exec_start), .exec_req(exec_req), .exec_done(exec_done),
    .exec_res(exec_res), .drive_seeking(drive_seeking),
    .result_status_zero(st0_o), .result_status_one(st1_o),
    .result_status_two(st2_o), .result_status_three(st3_o));
  exec_engine_model u_exec (
    .core_clk(core_clk), .nrst(nrst), .exec_start(exec_start),
    .delay(delay), .res_in(res), .exec_done(exec_done),
    .exec_res(exec_res));

  task automatic chk8(input string nm, input logic [7:0] ex,
                      input logic [7:0] got);
    n_tests++;
    if (got !== ex) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", nm, ex, got);
    end
  endtask

  task stop_test;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge core_clk) begin
    rd_d <= io_rd;
    rd_d2 <= rd_d;
    if (exec_start === 1'b1) n_start <= n_start + 1;
  end

  always @(negedge core_clk) begin
    if (rd_d2 === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (e[8]) chk8("data port", e[7:0], io_rdata);
    end
  end

  // ************************************************************
  // host side transfers
  // ************************************************************
  task automatic bus(input logic [9:0] a, input logic w,
                     input logic [7:0] d);
    io_addr = a;
    io_wdata = d;
    io_wr = w;
    io_rd = ~w;
    @(posedge core_clk);
    @(negedge core_clk);
    io_wr = 1'b0;
    io_rd = 1'b0;
    @(posedge core_clk);
    @(negedge core_clk);
  endtask

  // bits 7:6 gate every transfer; a full compare where flagged or after 40 polls with no match
  task automatic poll(input logic [1:0] w, input logic [8:0] full);
    int i;
    for (i = 0; i < 40; i++) begin
      exp_q.push_back(9'h000);
      bus(cmd_engine_pkg::MAIN_STATUS_ADDR, 1'b0, 8'h00);
      if (io_rdata[7:6] === w) break;
    end
    if (full[8] || i == 40) chk8("main status", full[7:0], io_rdata);
  endtask

  task automatic rnd();
    res = {$urandom(), $urandom()};
    delay = 5'($urandom_range(20, 0));
    drive_seeking = 4'($urandom());
  endtask

  function automatic bq_t dat7();
    return {res[63:56], res[55:48] & cmd_engine_pkg::ST1_ZERO_MASK,
            res[47:40] & cmd_engine_pkg::ST2_ZERO_MASK, res[31:24],
            res[23:16], res[15:8], res[7:0]};
  endfunction

  task automatic run(input bq_t b, input bq_t r, input logic ex,
                     input logic cut);
    int i;
    int s0;
    logic [7:0] drv;
    s0 = n_start;
    drv = {4'h0, drive_seeking};
    for (i = 0; i < b.size(); i++) begin
      poll(2'b10, 9'h080);
      if (i == b.size() - 1) chk8("early start", 8'(s0), 8'(n_start));
      bus(cmd_engine_pkg::DATA_PORT_ADDR, 1'b1, b[i]);
    end
    chk8("exec starts", 8'(s0 + int'(ex)), 8'(n_start));
    if (ex && delay > 5'd4) poll(2'b00, {1'b1, 8'h30 | drv});
    for (i = 0; i < r.size(); i++) begin
      poll(2'b11, {i == 0, 8'hd0 | drv});
      if (cut && i == 3) bus(cmd_engine_pkg::DATA_PORT_ADDR, 1'b1, 8'h0f);
      exp_q.push_back({1'b1, r[i]});
      bus(cmd_engine_pkg::DATA_PORT_ADDR, 1'b0, 8'h00);
    end
    poll(2'b10, {1'b1, 8'h80 | drv});
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    bq_t b;
    logic [7:0] op [8];
    logic [7:0] opt [8];
    int k;
    int j;
    op = '{8'h06, 8'h02, 8'h0c, 8'h05, 8'h09, 8'h11, 8'h19, 8'h1d};
    opt = '{8'he0, 8'h60, 8'he0, 8'hc0, 8'hc0, 8'he0, 8'he0, 8'he0};
    void'($urandom(32'he481));
    repeat (10) @(negedge core_clk);
    nrst = 1'b1;
    repeat (2) @(negedge core_clk);
    poll(2'b10, 9'h180);
    exp_q.push_back(9'h100);
    bus(cmd_engine_pkg::DATA_PORT_ADDR, 1'b0, 8'h00);
    bus(cmd_engine_pkg::MAIN_STATUS_ADDR, 1'b1, 8'h06);
    bus(10'h3f6, 1'b1, 8'h06);
    poll(2'b10, 9'h180);
    $display("test idle done");
    for (k = 0; k < 8; k++) begin
      rnd();
      b = {op[k] | (8'($urandom()) & opt[k])};
      for (j = 1; j < 9; j++)
        b.push_back(j == 2 ? 8'($urandom_range(76, 0)) : 8'($urandom()));
      run(b, dat7(), 1'b1, k == 0);
      chk8("code", op[k], {3'h0, exec_req.cmd_code});
      chk8("options", b[0] & 8'he0, {exec_req.multi_track,
        exec_req.double_density_sel, exec_req.bypass_deleted, 5'h00});
      chk8("unit", b[1] & 8'h07, {5'h00, exec_req.head_index,
        exec_req.drive_sel_hi, exec_req.drive_sel_lo});
      chk8("cylinder", b[2], exec_req.cylinder);
      chk8("last sector", b[6], exec_req.last_sector);
      if (k < 5) chk8("length", b[8], exec_req.transfer_length);
      chk8("status zero", res[63:56], st0_o);
      chk8("status one", res[55:48] & 8'hb7, st1_o);
      chk8("status two", res[47:40] & 8'h7f, st2_o);
      chk8("status three", res[39:32], st3_o);
      chk8("head", b[3], exec_req.head_no);
      chk8("sector", b[4], exec_req.sector);
      chk8("size", b[5], exec_req.size_code);
      chk8("gap", b[7], exec_req.gap_three_len);
    end
    $display("test data commands done");
    rnd();
    run({8'h0a | (8'($urandom()) & 8'h40), 8'($urandom())}, dat7(),
        1'b1, 1'b0);
    rnd();
    run({8'h08}, {res[63:56], res[31:24]}, 1'b1, 1'b0);
    rnd();
    run({8'h04, 8'h05}, {res[39:32]}, 1'b1, 1'b0);
    rnd();
    run({8'h0f, 8'h02, 8'h28}, none, 1'b1, 1'b0);
    rnd();
    run({8'h03, 8'h8f, 8'h10}, none, 1'b1, 1'b0);
    rnd();
    run({8'h07, 8'h01}, none, 1'b1, 1'b0);
    rnd();
    run({8'h4d, 8'h01, 8'h02, 8'h09, 8'h1b, 8'he5}, dat7(),
        1'b1, 1'b0);
    $display("test control commands done");
    foreach (op[k]) begin
      rnd();
      if (k < 4) run({op[k] ^ {k == 0, 2'b01, 5'h10}}, {8'h80},
                     1'b0, 1'b0);
    end
    rnd();
    run({8'h82}, {8'h80}, 1'b0, 1'b0);
    $display("test invalid opcodes done");
    rnd();
    poll(2'b10, 9'h080);
    bus(cmd_engine_pkg::DATA_PORT_ADDR, 1'b1, 8'h06);
    bus(cmd_engine_pkg::DATA_PORT_ADDR, 1'b1, 8'h01);
    nrst = 1'b0;
    repeat (2) @(negedge core_clk);
    nrst = 1'b1;
    repeat (2) @(negedge core_clk);
    poll(2'b10, {1'b1, 8'h80 | {4'h0, drive_seeking}});
    rnd();
    run({8'h04, 8'h02}, {res[39:32]}, 1'b1, 1'b0);
    $display("test reset mid command done");
    stop_test();
  end

  initial begin
    #500000;
    bad_count++;
    $display("watchdog expired");
    stop_test();
  end
endmodule // floppy_command_phase_engine_tb
